// file: core/liu_pkg.sv
/*
 * Constants of the global register bank of the eight-channel line interface:
 * register offsets, field positions, reset values and the neutral revision code.
 * Assumes an 8-bit register address and 8-bit register data.
 */
package liu_pkg;

    // Register port widths
    localparam int unsigned LIU_ADDR_W = 8;
    localparam int unsigned LIU_DATA_W = 8;
    localparam int unsigned LIU_CHANS  = 8;

    // Register offsets
    localparam logic [7:0] LIU_OFF_REVISION  = 8'h02;
    localparam logic [7:0] LIU_OFF_SOFT_RST  = 8'h04;
    localparam logic [7:0] LIU_OFF_MONITOR   = 8'h05;
    localparam logic [7:0] LIU_OFF_AUX_PIN   = 8'h06;
    localparam logic [7:0] LIU_OFF_REF_ROUTE = 8'h07;
    localparam logic [7:0] LIU_OFF_LINE_STD  = 8'h20;

    // Revision code; the value is arbitrary
    localparam logic [7:0] LIU_REVISION_DEFAULT = 8'h5a;

    // Monitor select field
    localparam int unsigned LIU_MON_LSB  = 0;
    localparam int unsigned LIU_MON_W    = 4;
    localparam int unsigned LIU_MON_TXB  = 3;
    localparam logic [3:0]  LIU_MON_RST  = 4'h0;

    // Auxiliary pin field positions
    localparam int unsigned LIU_PIN0_DIR_BIT = 0;
    localparam int unsigned LIU_PIN1_DIR_BIT = 1;
    localparam int unsigned LIU_PIN0_LVL_BIT = 2;
    localparam int unsigned LIU_PIN1_LVL_BIT = 3;
    localparam logic        LIU_PIN_DIR_RST  = 1'b1;
    localparam logic        LIU_PIN_LVL_RST  = 1'b0;

    // Reference clock route fields
    localparam int unsigned LIU_REF_A_LSB = 0;
    localparam int unsigned LIU_REF_B_LSB = 3;
    localparam int unsigned LIU_REF_SEL_W = 3;
    localparam logic [5:0]  LIU_REF_RST   = 6'h00;

    // Line standard select bit
    localparam int unsigned LIU_STD_BIT = 0;
    localparam logic        LIU_STD_RST = 1'b0;

endpackage

// file: core/liu_gpin.sv
/*
 * One general purpose pin cell: direction and level bits, pin sampling and
 * pin drive with separate output and output enable.
 * Assumes the pin input is synchronous to i_ref_clk.
 */
`timescale 1ns/1ns

module liu_gpin
(
    // Clock and resets
    input  wire logic i_ref_clk,
    input  wire logic i_rst,
    input  wire logic i_clear,
    // Register write
    input  wire logic i_wr,
    input  wire logic i_dir_d,
    input  wire logic i_level_d,
    // Pin
    input  wire logic i_pin,
    output logic      o_pin,
    output logic      o_pin_oe,
    // Register read view
    output logic      o_dir,
    output logic      o_level_rd
);
    import liu_pkg::*;

    logic dir_q;
    logic level_q;
    logic sample_q;

    ////////////////////////////////////////////////////////////////////////////
    // Direction bit, input after either reset
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || i_clear)
            dir_q <= LIU_PIN_DIR_RST;
        else if (i_wr)
            dir_q <= i_dir_d;
    end

    // Level bit; kept even while the pin is an input so a later turn is glitch free
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || i_clear)
            level_q <= LIU_PIN_LVL_RST;
        else if (i_wr)
            level_q <= i_level_d;
    end

    // Pin sample; input is synchronous so one stage is enough
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            sample_q <= 1'b0;
        else
            sample_q <= i_pin;
    end

    // Drive flops; enable follows direction one cycle later
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_pin    <= LIU_PIN_LVL_RST;
            o_pin_oe <= 1'b0;
        end
        else
        begin
            o_pin    <= level_q;
            o_pin_oe <= ~dir_q;
        end
    end

    // Read view: sampled pin when input, stored level when output
    assign o_dir      = dir_q;
    assign o_level_rd = dir_q ? sample_q : level_q;

endmodule

// file: core/liu_global_control_regs.sv
/*
 * Global register bank of the eight-channel line interface: revision code,
 * software reset trigger, line monitor selector, two general pins and two
 * reference clock routers, reached over a plain strobe register port.
 * Assumes strobes are single cycle, never both high, and that recovered
 * receive clocks are sampled as ordinary inputs synchronous to i_ref_clk.
 */
`timescale 1ns/1ns

module liu_global_control_regs
#(
    parameter logic [7:0] REVISION_CODE = liu_pkg::LIU_REVISION_DEFAULT
)
(
    // Clock and reset
    input  wire logic                            i_ref_clk,
    input  wire logic                            i_rst,
    // Register port
    input  wire logic [liu_pkg::LIU_ADDR_W-1:0]  i_addr,
    input  wire logic [liu_pkg::LIU_DATA_W-1:0]  i_wr_data,
    input  wire logic                            i_wr_en,
    input  wire logic                            i_rd_en,
    output logic      [liu_pkg::LIU_DATA_W-1:0]  o_rd_data,
    // Chip wide control
    output logic                                 o_soft_reset,
    output logic                                 o_driver_hiz,
    output logic                                 o_line_standard_select,
    // Line monitor selection
    output logic      [liu_pkg::LIU_CHANS-1:0]   o_monitor_rx_sel,
    output logic      [liu_pkg::LIU_CHANS-1:0]   o_monitor_tx_sel,
    // General pins
    input  wire logic [1:0]                      i_gpin,
    output logic      [1:0]                      o_gpin,
    output logic      [1:0]                      o_gpin_oe,
    // Recovered receive clocks and reference outputs
    input  wire logic [liu_pkg::LIU_CHANS-1:0]   i_rx_clk,
    output logic                                 o_reference_output_a,
    output logic                                 o_reference_output_b
);
    import liu_pkg::*;

    logic [LIU_MON_W-1:0]  monitor_select_q;
    logic [5:0]            ref_clock_route_q;
    logic                  line_std_q;
    logic                  soft_wr;
    logic                  global_wr;
    logic                  pin_wr;
    logic [1:0]            pin_dir;
    logic [1:0]            pin_level_rd;
    logic [LIU_DATA_W-1:0] rd_mux;
    logic [2:0]            ref_a_source_select;
    logic [2:0]            ref_b_source_select;

    ////////////////////////////////////////////////////////////////////////////
    // Write decode
    assign soft_wr   = i_wr_en && (i_addr == LIU_OFF_SOFT_RST);
    assign pin_wr    = i_wr_en && (i_addr == LIU_OFF_AUX_PIN);
    assign global_wr = i_wr_en && ((i_addr == LIU_OFF_MONITOR)
                                || (i_addr == LIU_OFF_AUX_PIN)
                                || (i_addr == LIU_OFF_REF_ROUTE)
                                || (i_addr == LIU_OFF_LINE_STD));

    assign ref_a_source_select = ref_clock_route_q[LIU_REF_A_LSB +: LIU_REF_SEL_W];
    assign ref_b_source_select = ref_clock_route_q[LIU_REF_B_LSB +: LIU_REF_SEL_W];

    ////////////////////////////////////////////////////////////////////////////
    // Monitor select; the upper nibble is never stored
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || soft_wr)
            monitor_select_q <= LIU_MON_RST;
        else if (i_wr_en && (i_addr == LIU_OFF_MONITOR))
            monitor_select_q <= i_wr_data[LIU_MON_LSB +: LIU_MON_W];
    end

    // Reference clock route, two 3-bit selectors
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || soft_wr)
            ref_clock_route_q <= LIU_REF_RST;
        else if (i_wr_en && (i_addr == LIU_OFF_REF_ROUTE))
            ref_clock_route_q <= i_wr_data[5:0];
    end

    // Line standard bit survives the soft reset; only the hard reset clears it
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            line_std_q <= LIU_STD_RST;
        else if (i_wr_en && (i_addr == LIU_OFF_LINE_STD))
            line_std_q <= i_wr_data[LIU_STD_BIT];
    end

    ////////////////////////////////////////////////////////////////////////////
    // Chip wide outputs
    // Reset pulse tells channel logic to return to defaults
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            o_soft_reset <= 1'b0;
        else
            o_soft_reset <= soft_wr;
    end

    // Drivers stay released until software configures the bank again
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst || soft_wr)
            o_driver_hiz <= 1'b1;
        else if (global_wr)
            o_driver_hiz <= 1'b0;
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            o_line_standard_select <= LIU_STD_RST;
        else
            o_line_standard_select <= line_std_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Monitor decode; code zero of each half means normal operation
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_monitor_rx_sel <= '0;
            o_monitor_tx_sel <= '0;
        end
        else
        begin
            o_monitor_rx_sel <= '0;
            o_monitor_tx_sel <= '0;
            if (monitor_select_q[2:0] != 3'h0)
            begin
                if (monitor_select_q[LIU_MON_TXB])
                    o_monitor_tx_sel <= 8'h01 << monitor_select_q[2:0];
                else
                    o_monitor_rx_sel <= 8'h01 << monitor_select_q[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reference clock routing; sampling the recovered clock costs a cycle of
    // skew but keeps every output on a flop
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
        begin
            o_reference_output_a <= 1'b0;
            o_reference_output_b <= 1'b0;
        end
        else
        begin
            o_reference_output_a <= i_rx_clk[ref_a_source_select];
            o_reference_output_b <= i_rx_clk[ref_b_source_select];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // General pins, one cell each
    liu_gpin u_pin0
    (
        .i_ref_clk  (i_ref_clk),
        .i_rst      (i_rst),
        .i_clear    (soft_wr),
        .i_wr       (pin_wr),
        .i_dir_d    (i_wr_data[LIU_PIN0_DIR_BIT]),
        .i_level_d  (i_wr_data[LIU_PIN0_LVL_BIT]),
        .i_pin      (i_gpin[0]),
        .o_pin      (o_gpin[0]),
        .o_pin_oe   (o_gpin_oe[0]),
        .o_dir      (pin_dir[0]),
        .o_level_rd (pin_level_rd[0])
    );

    liu_gpin u_pin1
    (
        .i_ref_clk  (i_ref_clk),
        .i_rst      (i_rst),
        .i_clear    (soft_wr),
        .i_wr       (pin_wr),
        .i_dir_d    (i_wr_data[LIU_PIN1_DIR_BIT]),
        .i_level_d  (i_wr_data[LIU_PIN1_LVL_BIT]),
        .i_pin      (i_gpin[1]),
        .o_pin      (o_gpin[1]),
        .o_pin_oe   (o_gpin_oe[1]),
        .o_dir      (pin_dir[1]),
        .o_level_rd (pin_level_rd[1])
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; unmapped and write-only offsets read zero
    always_comb
    begin
        rd_mux = '0;
        unique case (i_addr)
            LIU_OFF_REVISION:  rd_mux = REVISION_CODE;
            LIU_OFF_SOFT_RST:  rd_mux = 8'h00;
            LIU_OFF_MONITOR:   rd_mux = {4'h0, monitor_select_q};
            LIU_OFF_AUX_PIN:   rd_mux = {4'h0, pin_level_rd, pin_dir};
            LIU_OFF_REF_ROUTE: rd_mux = {2'h0, ref_clock_route_q};
            LIU_OFF_LINE_STD:  rd_mux = {7'h00, line_std_q};
            default:           rd_mux = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge i_ref_clk)
    begin
        if (i_rst)
            o_rd_data <= '0;
        else if (i_rd_en)
            o_rd_data <= rd_mux;
        else
            o_rd_data <= '0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_rst);

    sequence s_soft_write;
        i_wr_en && (i_addr == LIU_OFF_SOFT_RST);
    endsequence

    sequence s_rd(logic [7:0] off);
        i_rd_en && (i_addr == off);
    endsequence

    property p_rev_read;
        s_rd(LIU_OFF_REVISION) |=> (o_rd_data == REVISION_CODE);
    endproperty
    a_rev_read: assert property (p_rev_read)
        else $error("revision read wrong");

    property p_soft_clears;
        s_soft_write |=> (monitor_select_q == LIU_MON_RST)
                      && (ref_clock_route_q == LIU_REF_RST) && o_soft_reset;
    endproperty
    a_soft_clears: assert property (p_soft_clears)
        else $error("soft reset did not clear registers");

    property p_trigger_reads_zero;
        s_rd(LIU_OFF_SOFT_RST) |=> (o_rd_data == 8'h00);
    endproperty
    a_trigger_reads_zero: assert property (p_trigger_reads_zero)
        else $error("reset trigger read not zero");

    property p_hiz_after_soft;
        s_soft_write ##1 !global_wr |=> o_driver_hiz;
    endproperty
    a_hiz_after_soft: assert property (p_hiz_after_soft)
        else $error("drivers not released after soft reset");

    property p_std_kept;
        s_soft_write |=> (line_std_q == $past(line_std_q));
    endproperty
    a_std_kept: assert property (p_std_kept)
        else $error("line standard bit lost on soft reset");

    property p_mon_rx;
        !monitor_select_q[LIU_MON_TXB] |=>
            (o_monitor_tx_sel == 8'h00)
            && (o_monitor_rx_sel == (($past(monitor_select_q[2:0]) == 3'h0) ? 8'h00
                                     : (8'h01 << $past(monitor_select_q[2:0]))));
    endproperty
    a_mon_rx: assert property (p_mon_rx)
        else $error("receiver monitor decode wrong");

    property p_mon_tx;
        monitor_select_q[LIU_MON_TXB] |=>
            (o_monitor_rx_sel == 8'h00)
            && (o_monitor_tx_sel == (($past(monitor_select_q[2:0]) == 3'h0) ? 8'h00
                                     : (8'h01 << $past(monitor_select_q[2:0]))));
    endproperty
    a_mon_tx: assert property (p_mon_tx)
        else $error("transmitter monitor decode wrong");

    property p_pin1_input_after_soft;
        s_soft_write ##1 !pin_wr |=> !o_gpin_oe[1];
    endproperty
    a_pin1_input_after_soft: assert property (p_pin1_input_after_soft)
        else $error("pin 1 not input after soft reset");

    property p_pin0_input_after_soft;
        s_soft_write ##1 !pin_wr |=> !o_gpin_oe[0];
    endproperty
    a_pin0_input_after_soft: assert property (p_pin0_input_after_soft)
        else $error("pin 0 not input after soft reset");

    property p_pin1_drive;
        pin_wr && !i_wr_data[LIU_PIN1_DIR_BIT] ##1 !pin_wr
            |=> o_gpin_oe[1] && (o_gpin[1] == $past(i_wr_data[LIU_PIN1_LVL_BIT], 2));
    endproperty
    a_pin1_drive: assert property (p_pin1_drive)
        else $error("pin 1 drive level wrong");

    property p_pin1_read;
        s_rd(LIU_OFF_AUX_PIN) ##0 pin_dir[1] |=>
            (o_rd_data[LIU_PIN1_LVL_BIT] == $past(i_gpin[1], 2));
    endproperty
    a_pin1_read: assert property (p_pin1_read)
        else $error("pin 1 input read wrong");

    property p_pin0_read;
        s_rd(LIU_OFF_AUX_PIN) ##0 pin_dir[0] |=>
            (o_rd_data[LIU_PIN0_LVL_BIT] == $past(i_gpin[0], 2));
    endproperty
    a_pin0_read: assert property (p_pin0_read)
        else $error("pin 0 input read wrong");

    property p_ref_a;
        1'b1 |=> (o_reference_output_a == $past(i_rx_clk[ref_a_source_select]));
    endproperty
    a_ref_a: assert property (p_ref_a)
        else $error("reference A routing wrong");

    property p_ref_b;
        1'b1 |=> (o_reference_output_b == $past(i_rx_clk[ref_b_source_select]));
    endproperty
    a_ref_b: assert property (p_ref_b)
        else $error("reference B routing wrong");

    property p_reserved_zero;
        i_rd_en && ((i_addr == LIU_OFF_MONITOR) || (i_addr == LIU_OFF_AUX_PIN))
            |=> (o_rd_data[7:4] == 4'h0);
    endproperty
    a_reserved_zero: assert property (p_reserved_zero)
        else $error("reserved bits not zero");

endmodule

// file: bench/liu_global_control_regs_bench.sv
/*
 * Self-checking bench for the global register bank: register map, soft
 * reset, monitor decode, general pins and reference clock routing.
 * Assumes read data one cycle after the read strobe, single clock.
 */
`timescale 1ns/1ns

module liu_global_control_regs_bench;
    import liu_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Bench signals
    logic       clk;
    logic       rst;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] rd_data;
    logic       soft_rst;
    logic       hiz;
    logic       std_sel;
    logic [7:0] mon_rx;
    logic [7:0] mon_tx;
    logic [1:0] gpin_i;
    logic [1:0] gpin_o;
    logic [1:0] gpin_oe;
    logic [7:0] rx_clk;
    logic       ref_a;
    logic       ref_b;
    int         fail_count;
    int         total_checks;
    int         cycles;

    liu_global_control_regs liu_global_control_regs_i
    (
        .i_ref_clk              (clk),
        .i_rst                  (rst),
        .i_addr                 (addr),
        .i_wr_data              (wdata),
        .i_wr_en                (wr_en),
        .i_rd_en                (rd_en),
        .o_rd_data              (rd_data),
        .o_soft_reset           (soft_rst),
        .o_driver_hiz           (hiz),
        .o_line_standard_select (std_sel),
        .o_monitor_rx_sel       (mon_rx),
        .o_monitor_tx_sel       (mon_tx),
        .i_gpin                 (gpin_i),
        .o_gpin                 (gpin_o),
        .o_gpin_oe              (gpin_oe),
        .i_rx_clk               (rx_clk),
        .o_reference_output_a   (ref_a),
        .o_reference_output_b   (ref_b)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock and hang guard; the whole run needs well under 2000 cycles
    initial clk = 1'b0;
    always #10 clk = ~clk;

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            print_verdict();
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared tasks
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Strobe released a cycle later, so back-to-back calls leave a gap
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr_en <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask

    task automatic rchk(input string name, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clk);
        rd_en <= 1'b0;
        #1;
        chk(name, rd_data, exp);
    endtask

    // Registered outputs lag the register by one more cycle
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    function automatic logic [7:0] mon_exp(input logic [3:0] c, input logic tx);
        return (c[3] == tx && c[2:0] != 3'h0) ? 8'h01 << c[2:0] : 8'h00;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [7:0] v;
        logic [2:0] b;
        rst = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        gpin_i = 2'b00;
        rx_clk = 8'h00;
        fail_count = 0;
        total_checks = 0;
        cycles = 0;
        void'($urandom(32'h1d19));
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        // Reset values, read-only and unmapped places
        rchk("revision", LIU_OFF_REVISION, LIU_REVISION_DEFAULT);
        @(posedge clk);
        #1;
        chk("rd_idle", rd_data, 8'h00);
        wr(LIU_OFF_REVISION, 8'ha5);
        rchk("revision_kept", LIU_OFF_REVISION, LIU_REVISION_DEFAULT);
        rchk("trigger", LIU_OFF_SOFT_RST, 8'h00);
        rchk("monitor_rst", LIU_OFF_MONITOR, 8'h00);
        rchk("pins_rst", LIU_OFF_AUX_PIN, 8'h03);
        rchk("route_rst", LIU_OFF_REF_ROUTE, 8'h00);
        rchk("unmapped", 8'h41, 8'h00);
        chk("pin_oe_rst", {6'h0, gpin_oe}, 8'h00);
        // Every monitor code, reserved bits random
        for (int c = 0; c < 16; c++)
        begin
            v = 8'($urandom);
            v[3:0] = c[3:0];
            wr(LIU_OFF_MONITOR, v);
            settle();
            chk("mon_rx", mon_rx, mon_exp(v[3:0], 1'b0));
            chk("mon_tx", mon_tx, mon_exp(v[3:0], 1'b1));
            rchk("monitor", LIU_OFF_MONITOR, {4'h0, v[3:0]});
        end
        wr(8'h08, 8'h00);
        rchk("monitor_kept", LIU_OFF_MONITOR, 8'h0f);
        // Every source code on both reference outputs with random clocks
        for (int a = 0; a < 8; a++)
        begin
            b = 3'(a + 4);
            v = 8'($urandom);
            wr(LIU_OFF_REF_ROUTE, {v[7:6], b, 3'(a)});
            rchk("route", LIU_OFF_REF_ROUTE, {2'b00, b, 3'(a)});
            repeat (4)
            begin
                v = 8'($urandom);
                @(posedge clk);
                rx_clk <= v;
                @(posedge clk);
                #1;
                chk("ref_a", {7'h0, ref_a}, {7'h0, v[a]});
                chk("ref_b", {7'h0, ref_b}, {7'h0, v[b]});
            end
        end
        // Pin directions in all combinations, random levels and pin inputs
        for (int k = 0; k < 8; k++)
        begin
            v = 8'($urandom);
            v[1:0] = 2'(k);
            @(posedge clk);
            gpin_i <= v[5:4];
            wr(LIU_OFF_AUX_PIN, v);
            settle();
            chk("pin_oe", {6'h0, gpin_oe}, {6'h0, ~v[1:0]});
            chk("pin_out", {6'h0, gpin_o & ~v[1:0]}, {6'h0, v[3:2] & ~v[1:0]});
            chk("pin_level_kept", {6'h0, gpin_o}, {6'h0, v[3:2]});
            rchk("pins", LIU_OFF_AUX_PIN, {4'h0, v[1] ? v[5] : v[3], v[0] ? v[4] : v[2],
                v[1:0]});
        end
        // Soft reset with everything away from its default
        wr(LIU_OFF_LINE_STD, 8'h01);
        wr(LIU_OFF_MONITOR, 8'h0b);
        wr(LIU_OFF_AUX_PIN, 8'h0c);
        settle();
        chk("std_set", {7'h0, std_sel}, 8'h01);
        chk("hiz_clear", {7'h0, hiz}, 8'h00);
        wr(LIU_OFF_SOFT_RST, 8'($urandom));
        #1;
        chk("soft_pulse", {7'h0, soft_rst}, 8'h01);
        @(posedge clk);
        #1;
        chk("soft_end", {7'h0, soft_rst}, 8'h00);
        chk("hiz", {7'h0, hiz}, 8'h01);
        settle();
        chk("std_kept", {7'h0, std_sel}, 8'h01);
        chk("mon_tx_rst", mon_tx, 8'h00);
        chk("pin_oe_srst", {6'h0, gpin_oe}, 8'h00);
        chk("pin_out_srst", {6'h0, gpin_o}, 8'h00);
        rchk("monitor_srst", LIU_OFF_MONITOR, 8'h00);
        rchk("route_srst", LIU_OFF_REF_ROUTE, 8'h00);
        rchk("pins_srst", LIU_OFF_AUX_PIN, {4'h0, gpin_i, 2'b11});
        rchk("trigger_srst", LIU_OFF_SOFT_RST, 8'h00);
        rchk("std_rd", LIU_OFF_LINE_STD, 8'h01);
        print_verdict();
    end

endmodule
